/* File: hw/rate_measure_regs.vh */
// Register offsets, field positions, defaults and timing for the rate/window block
`ifndef RATE_MEASURE_REGS_VH
`define RATE_MEASURE_REGS_VH

// Clock and sample time base
`define CLK_SYS_HZ 10000000
`define SAMPLE_STEP_MS 10
`define MS_PER_S 1000
`define HZ_PER_STEP (`MS_PER_S / `SAMPLE_STEP_MS)

// Sample period in steps of 10 ms: 10 ms .. 3 s, default 1 s
`define SAMPLE_MIN 9'h001
`define SAMPLE_MAX 9'h12c
`define SAMPLE_DEF 9'h064

// Cycles that counting and outputs stay parked while a configuration loads
`define LOAD_CYCLES 3'h4

// Input words (read only), 16 bits each
`define IN_FREQ0_LO 8'h00
`define IN_FREQ0_HI 8'h04
`define IN_FREQ1_LO 8'h08
`define IN_FREQ1_HI 8'h0c
`define IN_TOT0_LO 8'h10
`define IN_TOT0_HI 8'h14
`define IN_TOT1_LO 8'h18
`define IN_TOT1_HI 8'h1c
`define IN_STATUS 8'h20
`define ST_LOADING_BIT 0
`define ST_CFG_ERR_BIT 15

// Output words (live)
`define OUT_CTRL 8'h44
`define OUT_DUTY0 8'h48
`define OUT_DUTY1 8'h4c
`define OUT_FORCE_BIT 0
`define OUT_ENABLE_BIT 1
`define OUT_NIBBLE 4

// Configuration words (shadowed, taken on apply)
`define CFG_SAMPLE 8'h80
`define CFG_PWM_PER0 8'h84
`define CFG_PWM_PER1 8'h88
`define CFG_MODE 8'h8c
`define CFG_APPLY 8'h90
`define MODE_PWM_EN_LSB 0
`define MODE_ASSIGN_LSB 8
`define CFG_WIN_REGION 3'h5

`endif

/* File: hw/rate_divider.v */
// Sequential restoring divider turning a scaled pulse count into a frequency
`timescale 1ns/1ps
module rate_divider (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Request
    input wire start,
    input wire [39:0] dividend,
    input wire [8:0] divisor,
    // Answer
    output reg done,
    output wire [31:0] quotient
);
    localparam [5:0] STEPS = 6'h28; // One step per dividend bit

    reg [39:0] quo; // Dividend shifting out, quotient shifting in
    reg [8:0] rem; // Partial remainder, always below divisor
    reg [5:0] steps_left; // Steps still to go
    reg busy; // Division in progress

    wire [9:0] shifted = {rem, quo[39]}; // Remainder with next bit brought down
    wire [9:0] diff = shifted - {1'b0, divisor}; // Trial subtraction

    // Quotient truncates toward zero; upper bits are dropped on overflow
    assign quotient = quo[31:0];

    // One quotient bit per cycle; 40 cycles is far inside a 10 ms period
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            quo <= 40'h0;
            rem <= 9'h000;
            steps_left <= 6'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                // New request restarts the divider
                quo <= dividend;
                rem <= 9'h000;
                steps_left <= STEPS;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                // Keep the trial result only when it did not go negative
                if (!diff[9])
                begin
                    rem <= diff[8:0];
                    quo <= {quo[38:0], 1'b1};
                end
                else
                begin
                    rem <= shifted[8:0];
                    quo <= {quo[38:0], 1'b0};
                end
                steps_left <= steps_left - 6'h01;
                if (steps_left == 6'h01)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // rate_divider

/* File: hw/rate_measure_window_outputs.v */
// Rate measurement, PWM and circular count-window outputs behind an APB slave
`timescale 1ns/1ps
`include "rate_measure_regs.vh"

module rate_measure_window_outputs #(
    parameter TICK_CYCLES = `CLK_SYS_HZ / `MS_PER_S * `SAMPLE_STEP_MS
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg pready,
    output reg [31:0] prdata,
    output reg pslverr,
    // Counter pins, one bit per channel
    input wire [1:0] phase_a_in,
    input wire [1:0] phase_b_in,
    input wire [1:0] gate_z_in,
    // Switched outputs
    output reg [3:0] out_drive
);
    localparam [31:0] TICK_LAST = TICK_CYCLES - 1; // Last cycle of a 10 ms step
    localparam ST_RUN = 1'b0; // Normal counting
    localparam ST_LOAD = 1'b1; // New parameters going in

    // Circular window test: ON not above OFF gives on inside, else on outside
    function win_hit;
        input [31:0] cnt;
        input [31:0] on_v;
        input [31:0] off_v;
        begin
            if (on_v <= off_v)
                win_hit = (cnt >= on_v) && (cnt < off_v);
            else
                win_hit = (cnt >= on_v) || (cnt < off_v);
        end
    endfunction

    // Register space split into words; window block decoded apart
    function in_win_region;
        input [7:0] a;
        begin
            in_win_region = (a[7:5] == `CFG_WIN_REGION);
        end
    endfunction

    // Pin conditioning and pulse detection
    reg [1:0] a_s1; // First stage, read only by second stage
    reg [1:0] a_s2; // Second stage
    reg [1:0] a_s3; // Third stage
    reg [1:0] a_flt; // Accepted level
    reg [1:0] a_prev; // Level one cycle earlier
    wire [1:0] pulse = a_flt & ~a_prev; // Rising edge of accepted level

    // Time base and measurement state
    reg [31:0] tick_cnt; // Cycles within the 10 ms step
    reg tick; // One-cycle 10 ms enable
    reg [8:0] step_cnt; // Steps elapsed in the current period
    reg [31:0] live_cnt [0:1]; // Running pulse sum per channel
    reg [31:0] snap_cnt [0:1]; // Count captured at period end
    reg [31:0] total [0:1]; // Published pulse total
    reg [31:0] freq [0:1]; // Published frequency
    reg div_start; // Kick both dividers
    wire [1:0] div_done; // Divider answers
    wire [31:0] div_q [0:1]; // Divider results

    // Active configuration and its shadow
    reg [8:0] sample_per; // Active period in 10 ms steps
    reg [8:0] sh_sample; // Shadow period
    reg [15:0] pwm_per [0:1]; // Active PWM period in clock cycles
    reg [15:0] sh_pwm_per [0:1]; // Shadow PWM period
    reg [15:0] mode; // Active PWM enables and output assignment
    reg [15:0] sh_mode; // Shadow mode word
    reg [31:0] win_on [0:3]; // Active ON values
    reg [31:0] win_off [0:3]; // Active OFF values
    reg [31:0] sh_on [0:3]; // Shadow ON values
    reg [31:0] sh_off [0:3]; // Shadow OFF values

    // Live output words
    reg [15:0] out_ctrl; // Enable and force bits
    reg [15:0] duty [0:1]; // PWM duty per channel
    reg [15:0] pwm_cnt [0:1]; // PWM period counter

    // Loader
    reg load_state; // ST_RUN or ST_LOAD
    reg [2:0] load_cnt; // Cycles left in load
    reg cfg_err; // Last apply was rejected

    // Bus decode
    reg [31:0] rd_val; // Read data for the addressed word
    reg bad_addr; // Unmapped or write to read-only
    wire bus_wr = psel && penable && pready && pwrite; // Write takes effect here
    wire apply_req = bus_wr && (paddr == `CFG_APPLY) && pwdata[0];
    wire period_ok = (sh_sample >= `SAMPLE_MIN) && (sh_sample <= `SAMPLE_MAX);
    wire run = (load_state == ST_RUN);
    wire period_end = tick && (step_cnt == sample_per - 9'h001);

    // Window inputs and results
    wire [3:0] win_act; // Window currently on
    reg [3:0] next_out; // Output levels for the next cycle
    integer j; // Loop index of the register process only, so k keeps one driver
    genvar g;

    // Three-flop synchroniser per channel; only phase one is sampled
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_pin
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    a_s1[g] <= 1'b0;
                    a_s2[g] <= 1'b0;
                    a_s3[g] <= 1'b0;
                    a_flt[g] <= 1'b0;
                    a_prev[g] <= 1'b0;
                end
                else
                begin
                    a_s1[g] <= phase_a_in[g];
                    a_s2[g] <= a_s1[g];
                    a_s3[g] <= a_s2[g];
                    // Change counts only once two stages agree
                    if (a_s2[g] == a_s3[g])
                        a_flt[g] <= a_s3[g];
                    a_prev[g] <= a_flt[g];
                end
            end
        end
    endgenerate

    // Second phase and gate inputs play no part in rate measurement
    wire unused_pins = ^{phase_b_in, gate_z_in};

    // 10 ms tick and period boundary; cleared to zero while loading
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
            step_cnt <= 9'h000;
        end
        else if (!run)
        begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
            step_cnt <= 9'h000;
        end
        else
        begin
            tick <= (tick_cnt == TICK_LAST);
            tick_cnt <= (tick_cnt == TICK_LAST) ? 32'h0 : tick_cnt + 32'h1;
            if (tick)
                step_cnt <= (step_cnt == sample_per - 9'h001) ? 9'h000 : step_cnt + 9'h001;
        end
    end

    // Per-channel pulse accumulation, period capture, PWM time base
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_chan
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    live_cnt[g] <= 32'h0;
                    snap_cnt[g] <= 32'h0;
                    total[g] <= 32'h0;
                    freq[g] <= 32'h0;
                    pwm_cnt[g] <= 16'h0000;
                end
                else if (!run)
                begin
                    live_cnt[g] <= 32'h0;
                    pwm_cnt[g] <= 16'h0000;
                end
                else
                begin
                    // A pulse on the boundary cycle opens the next period
                    if (period_end)
                    begin
                        snap_cnt[g] <= live_cnt[g];
                        live_cnt[g] <= {31'h0, pulse[g]};
                    end
                    else if (pulse[g])
                        live_cnt[g] <= live_cnt[g] + 32'h1;
                    // Total and frequency are published together
                    if (div_done[g])
                    begin
                        total[g] <= snap_cnt[g];
                        freq[g] <= div_q[g];
                    end
                    // PWM period counter wraps at the programmed period
                    if (pwm_per[g] == 16'h0000 || pwm_cnt[g] == pwm_per[g] - 16'h0001)
                        pwm_cnt[g] <= 16'h0000;
                    else
                        pwm_cnt[g] <= pwm_cnt[g] + 16'h0001;
                end
            end

            // Frequency = count * (steps per second) / period steps
            rate_divider u_div (
                .clk_sys(clk_sys),
                .rst(rst),
                .start(div_start),
                .dividend({8'h00, snap_cnt[g]} * `HZ_PER_STEP),
                .divisor(sample_per),
                .done(div_done[g]),
                .quotient(div_q[g])
            );
        end
    endgenerate

    // Divider starts the cycle after the snapshot is stable
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            div_start <= 1'b0;
        else
            div_start <= run && period_end;
    end

    // Windows: the first one of a channel in PWM mode follows the PWM counter
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_win
            wire pwm_mode = mode[`MODE_PWM_EN_LSB + g / 2] && (g % 2 == 0);
            wire [31:0] w_cnt = pwm_mode ? {16'h0000, pwm_cnt[g / 2]} : live_cnt[g / 2];
            wire [31:0] w_on = pwm_mode ? 32'h0 : win_on[g];
            wire [31:0] w_off = pwm_mode ? {16'h0000, duty[g / 2]} : win_off[g];
            // Compared every cycle, so refreshed counts act at once
            assign win_act[g] = win_hit(w_cnt, w_on, w_off);
        end
    endgenerate

    // Output gating: assignment, enable, force, load parking
    integer k;
    always @*
    begin
        next_out = 4'h0;
        for (k = 0; k < 4; k = k + 1)
        begin
            if (!out_ctrl[k * `OUT_NIBBLE + `OUT_ENABLE_BIT])
                next_out[k] = 1'b0;
            else if (out_ctrl[k * `OUT_NIBBLE + `OUT_FORCE_BIT])
                next_out[k] = 1'b1;
            else
                next_out[k] = win_act[mode[`MODE_ASSIGN_LSB + 2 * k +: 2]];
        end
        if (!run)
            next_out = 4'h0;
    end

    // Output drive registered straight from the gating
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            out_drive <= 4'h0;
        else
            out_drive <= next_out;
    end

    // Read mux; window shadows sit at 8-byte strides
    always @*
    begin
        rd_val = 32'h0;
        bad_addr = 1'b0;
        case (paddr)
            `IN_FREQ0_LO: rd_val = {16'h0000, freq[0][15:0]};
            `IN_FREQ0_HI: rd_val = {16'h0000, freq[0][31:16]};
            `IN_FREQ1_LO: rd_val = {16'h0000, freq[1][15:0]};
            `IN_FREQ1_HI: rd_val = {16'h0000, freq[1][31:16]};
            `IN_TOT0_LO: rd_val = {16'h0000, total[0][15:0]};
            `IN_TOT0_HI: rd_val = {16'h0000, total[0][31:16]};
            `IN_TOT1_LO: rd_val = {16'h0000, total[1][15:0]};
            `IN_TOT1_HI: rd_val = {16'h0000, total[1][31:16]};
            `IN_STATUS:
            begin
                rd_val[`ST_CFG_ERR_BIT] = cfg_err;
                rd_val[`ST_LOADING_BIT] = !run;
            end
            `OUT_CTRL: rd_val = {16'h0000, out_ctrl};
            `OUT_DUTY0: rd_val = {16'h0000, duty[0]};
            `OUT_DUTY1: rd_val = {16'h0000, duty[1]};
            `CFG_SAMPLE: rd_val = {23'h0, sh_sample};
            `CFG_PWM_PER0: rd_val = {16'h0000, sh_pwm_per[0]};
            `CFG_PWM_PER1: rd_val = {16'h0000, sh_pwm_per[1]};
            `CFG_MODE: rd_val = {16'h0000, sh_mode};
            `CFG_APPLY: rd_val = 32'h0;
            default:
            begin
                if (in_win_region(paddr) && paddr[1:0] == 2'b00)
                    rd_val = paddr[2] ? sh_off[paddr[4:3]] : sh_on[paddr[4:3]];
                else
                    bad_addr = 1'b1;
            end
        endcase
        // Input words cannot be written
        if (pwrite && paddr <= `IN_STATUS)
            bad_addr = 1'b1;
    end

    // APB handshake: no wait state, answers registered in the setup cycle come from flops
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0 : rd_val;
            pslverr <= bad_addr;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Register writes, configuration check and load sequence
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            out_ctrl <= 16'h0000;
            duty[0] <= 16'h0000;
            duty[1] <= 16'h0000;
            sh_sample <= `SAMPLE_DEF;
            sample_per <= `SAMPLE_DEF;
            sh_pwm_per[0] <= 16'h0000;
            sh_pwm_per[1] <= 16'h0000;
            pwm_per[0] <= 16'h0000;
            pwm_per[1] <= 16'h0000;
            sh_mode <= 16'h0000;
            mode <= 16'h0000;
            for (j = 0; j < 4; j = j + 1)
            begin
                sh_on[j] <= 32'h0;
                sh_off[j] <= 32'h0;
                win_on[j] <= 32'h0;
                win_off[j] <= 32'h0;
            end
            load_state <= ST_RUN;
            load_cnt <= 3'h0;
            cfg_err <= 1'b0;
        end
        else
        begin
            if (bus_wr && !bad_addr)
            begin
                case (paddr)
                    `OUT_CTRL: out_ctrl <= pwdata[15:0];
                    `OUT_DUTY0: duty[0] <= pwdata[15:0];
                    `OUT_DUTY1: duty[1] <= pwdata[15:0];
                    `CFG_SAMPLE: sh_sample <= pwdata[8:0];
                    `CFG_PWM_PER0: sh_pwm_per[0] <= pwdata[15:0];
                    `CFG_PWM_PER1: sh_pwm_per[1] <= pwdata[15:0];
                    `CFG_MODE: sh_mode <= pwdata[15:0];
                    default:
                    begin
                        if (in_win_region(paddr) && paddr[2])
                            sh_off[paddr[4:3]] <= pwdata;
                        else if (in_win_region(paddr))
                            sh_on[paddr[4:3]] <= pwdata;
                    end
                endcase
            end
            case (load_state)
                ST_RUN:
                begin
                    // A bad shadow is refused and the old set kept running
                    if (apply_req && !period_ok)
                        cfg_err <= 1'b1;
                    else if (apply_req)
                    begin
                        cfg_err <= 1'b0;
                        load_state <= ST_LOAD;
                        load_cnt <= `LOAD_CYCLES;
                    end
                end
                ST_LOAD:
                begin
                    load_cnt <= load_cnt - 3'h1;
                    if (load_cnt == 3'h1)
                    begin
                        sample_per <= sh_sample;
                        pwm_per[0] <= sh_pwm_per[0];
                        pwm_per[1] <= sh_pwm_per[1];
                        mode <= sh_mode;
                        for (j = 0; j < 4; j = j + 1)
                        begin
                            win_on[j] <= sh_on[j];
                            win_off[j] <= sh_off[j];
                        end
                        load_state <= ST_RUN;
                    end
                end
                default: load_state <= ST_RUN;
            endcase
        end
    end
endmodule // rate_measure_window_outputs

/* File: test/rate_measure_window_outputs_props.sv */
// Checker for bus timing, load parking and output enable/force
`timescale 1ns/1ps
`include "rate_measure_regs.vh"
module rate_measure_window_outputs_props (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    // Pins
    input wire [1:0] phase_a_in,
    input wire [1:0] phase_b_in,
    input wire [1:0] gate_z_in,
    input wire [3:0] out_drive
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire acc = psel && penable && pready; // Committed transfer
    wire wr = acc && pwrite;
    logic [15:0] ctrl; // Mirror of output control word
    logic [8:0] smp; // Mirror of sample period shadow
    logic [3:0] en_p;
    logic [3:0] fo_p;
    logic [2:0] ld; // Generous load countdown, design parks for fewer
    logic ld_p;
    wire [3:0] en = {ctrl[13], ctrl[9], ctrl[5], ctrl[1]};
    wire [3:0] fo = {ctrl[12], ctrl[8], ctrl[4], ctrl[0]};
    wire [3:0] frc = en & fo & en_p & fo_p; // Forced for two cycles
    wire smp_ok = smp >= `SAMPLE_MIN && smp <= `SAMPLE_MAX;
    wire apply_ok = wr && paddr == `CFG_APPLY && pwdata[0] && smp_ok;
    // Mirrors follow committed writes only
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= 16'h0000;
            smp <= `SAMPLE_DEF;
            ld <= 3'h0;
            en_p <= 4'h0;
            fo_p <= 4'h0;
            ld_p <= 1'b0;
        end
        else
        begin
            if (wr && paddr == `OUT_CTRL)
                ctrl <= pwdata[15:0];
            if (wr && paddr == `CFG_SAMPLE)
                smp <= pwdata[8:0];
            ld <= apply_ok ? 3'h6 : (ld != 3'h0 ? ld - 3'h1 : 3'h0);
            en_p <= en;
            fo_p <= fo;
            ld_p <= ld != 3'h0;
        end
    end
    sequence apply_taken;
        apply_ok;
    endsequence
    sequence parked;
        (out_drive == 4'h0) [*2];
    endsequence
    a_load_parks_outputs: assert property (apply_taken |-> ##2 parked)
        else $error("outputs not parked during load");
    a_disabled_held_off: assert property ((out_drive & ~en & ~en_p) == 4'h0)
        else $error("disabled output driven");
    a_force_turns_on: assert property (ld == 3'h0 && !ld_p |-> (out_drive & frc) == frc)
        else $error("forced output not on");
    a_input_read_only: assert property (wr && paddr <= `IN_STATUS |-> pslverr)
        else $error("write to input word accepted");
    a_input_read_ok: assert property (acc && !pwrite && paddr <= `IN_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("input word read refused");
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule // rate_measure_window_outputs_props

bind rate_measure_window_outputs rate_measure_window_outputs_props props_u (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .phase_a_in(phase_a_in), .phase_b_in(phase_b_in), .gate_z_in(gate_z_in),
    .out_drive(out_drive)
);

/* File: test/pulse_source.sv */
// Pulse source standing in for the encoder on the counter pins
`timescale 1ns/1ps
module pulse_source (
    // Clock
    input wire clk_sys,
    // Counter pins
    output logic [1:0] phase_a_in,
    output wire [1:0] phase_b_in,
    output wire [1:0] gate_z_in
);
    logic [2:0] tog = 3'h0; // Noise so any leak of unused pins shows in counts
    initial phase_a_in = 2'h0;
    assign phase_b_in = {2{tog[1]}};
    assign gate_z_in = {2{tog[2]}};
    always @(posedge clk_sys)
        tog <= tog + 3'h1;
    // Three cycles high, three low: clears the two-sample filter
    task automatic send(input int n, input logic [1:0] mask);
        for (int i = 0; i < n; i++)
        begin
            phase_a_in <= mask;
            repeat (3) @(posedge clk_sys);
            phase_a_in <= 2'h0;
            repeat (3) @(posedge clk_sys);
        end
    endtask
endmodule // pulse_source

/* File: test/rate_measure_window_outputs_tb.sv */
// Self-checking bench for the rate/window block
`timescale 1ns/1ps
`include "rate_measure_regs.vh"
module rate_measure_window_outputs_tb;
    logic clk_sys;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire pready;
    wire [31:0] prdata;
    wire pslverr;
    wire [1:0] phase_a_in;
    wire [1:0] phase_b_in;
    wire [1:0] gate_z_in;
    wire [3:0] out_drive;
    int error_cnt = 0;
    int cmp_count = 0;
    int hi;
    // Totals and rates expected after 5 and 3 pulses in a 100 ms period
    logic [31:0] exp_r [8] = '{32'd50, 0, 32'd30, 0, 32'd5, 0, 32'd3, 0};
    // Ten-cycle time base keeps periods short
    rate_measure_window_outputs #(.TICK_CYCLES(10)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .phase_a_in(phase_a_in),
        .phase_b_in(phase_b_in), .gate_z_in(gate_z_in), .out_drive(out_drive)
    );
    pulse_source src_u (
        .clk_sys(clk_sys), .phase_a_in(phase_a_in), .phase_b_in(phase_b_in),
        .gate_z_in(gate_z_in)
    );
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk_data(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t data got %h exp %h", $time, g, x);
        end
    endtask
    task automatic chk_out(input logic [3:0] g, input logic [3:0] x);
        cmp_count++;
        if (g !== x)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t outputs got %h exp %h", $time, g, x);
        end
    endtask
    // One bus transfer; holds the request until ready, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] x, input logic xe);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk_sys);
        end
        if (n >= 50)
            error_cnt++;
        chk_data(prdata, x);
        chk_data({31'h0, pslverr}, {31'h0, xe});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        bus(1'b0, `CFG_SAMPLE, 32'h0, 32'h64, 1'b0);
        chk_out(out_drive, 4'h0);
        bus(1'b0, 8'h30, 32'h0, 32'h0, 1'b1);
        bus(1'b1, `IN_TOT0_LO, 32'h5, 32'h0, 1'b1);
        bus(1'b1, 8'ha8, 32'h5, 32'h0, 1'b0);
        bus(1'b1, 8'hac, 32'h2, 32'h0, 1'b0);
        bus(1'b1, 8'hb8, 32'h2, 32'h0, 1'b0);
        bus(1'b1, 8'hbc, 32'h5, 32'h0, 1'b0);
        bus(1'b1, `CFG_PWM_PER0, 32'ha, 32'h0, 1'b0);
        bus(1'b1, `CFG_MODE, 32'h7001, 32'h0, 1'b0);
        bus(1'b1, `CFG_SAMPLE, 32'ha, 32'h0, 1'b0);
        bus(1'b1, `OUT_DUTY0, 32'h3, 32'h0, 1'b0);
        bus(1'b1, `OUT_CTRL, 32'h2232, 32'h0, 1'b0);
        bus(1'b1, `CFG_APPLY, 32'h1, 32'h0, 1'b0);
        @(posedge clk_sys);
        chk_out(out_drive, 4'h0);
        repeat (20) @(posedge clk_sys);
        bus(1'b0, `IN_STATUS, 32'h0, 32'h0, 1'b0);
        chk_out(out_drive & 4'he, 4'ha);
        hi = 0;
        // Count on-cycles of the PWM output over ten periods
        repeat (100)
        begin
            @(posedge clk_sys);
            if (out_drive[0] === 1'b1)
                hi++;
        end
        chk_data(32'(hi), 32'd30);
        src_u.send(3, 2'b11);
        src_u.send(2, 2'b01);
        repeat (125) @(posedge clk_sys);
        foreach (exp_r[i])
            bus(1'b0, 8'(4 * i), 32'h0, exp_r[i], 1'b0);
        repeat (80) @(posedge clk_sys);
        bus(1'b0, `IN_FREQ0_LO, 32'h0, 32'h0, 1'b0);
        bus(1'b0, `IN_TOT0_LO, 32'h0, 32'h0, 1'b0);
        bus(1'b1, `CFG_SAMPLE, 32'h12d, 32'h0, 1'b0);
        bus(1'b1, `CFG_APPLY, 32'h1, 32'h0, 1'b0);
        repeat (2) @(posedge clk_sys);
        bus(1'b0, `IN_STATUS, 32'h0, 32'h8000, 1'b0);
        chk_out(out_drive & 4'he, 4'ha);
        bus(1'b1, `OUT_CTRL, 32'h0232, 32'h0, 1'b0);
        @(posedge clk_sys);
        chk_out(out_drive & 4'h8, 4'h0);
        conclude();
    end
    // Watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        error_cnt++;
        conclude();
    end
endmodule // rate_measure_window_outputs_tb
